/* src/cmpc_pkg.sv */
// shared constants of the comparator output control block
package cmpc_pkg;

    // ==================================================
    // register offsets (byte addresses, one word each)
    localparam logic [7:0] OFS_CTRL0 = 8'h00;
    localparam logic [7:0] OFS_CTRL1 = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_MASK = 8'h0c;

    // ==================================================
    // widths
    localparam int unsigned REG_W = 8;
    localparam int unsigned EVT_W = 2;
    localparam int unsigned POS_SEL_W = 2;
    localparam int unsigned NEG_SEL_W = 3;

    // ==================================================
    // compare_control_zero fields
    localparam int unsigned C0_RESYNC = 0;
    localparam int unsigned C0_HYST = 1;
    localparam int unsigned C0_SPEED = 2;
    localparam int unsigned C0_INVERT = 4;
    localparam int unsigned C0_RESULT = 6;
    localparam logic [7:0] C0_WR_MASK = 8'h17;

    // ==================================================
    // compare_control_one fields
    localparam int unsigned C1_NEG_LSB = 0;
    localparam int unsigned C1_POS_LSB = 4;
    localparam int unsigned C1_FALL = 6;
    localparam int unsigned C1_RISE = 7;
    localparam logic [7:0] C1_WR_MASK = 8'hf7;

    // ==================================================
    // event status / mask fields
    localparam int unsigned EV_CMP = 0;
    localparam int unsigned EV_OUT = 1;

    // ==================================================
    // values after reset
    localparam logic [7:0] RST_CTRL0 = 8'h04;
    localparam logic [7:0] RST_CTRL1 = 8'h00;
    localparam logic [1:0] RST_EVT = 2'h0;
    localparam logic RST_LEVEL = 1'b0;

    // ==================================================
    // bus slave states
    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK = 1'b1
    } cmpc_bus_t;

endpackage

/* src/cmpc_edge.sv */
// edge detector: compares a level with its value one cycle earlier
`timescale 1ns/1ps

module cmpc_edge #(
    parameter logic RST_VAL = 1'b0
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // sampled level
    input wire logic d_i,
    // edge pulses, one cycle each
    output logic rise_o,
    output logic fall_o
);

    typedef struct packed {
        logic prev;
    } cmpc_edge_st_t;

    cmpc_edge_st_t st_ff;
    cmpc_edge_st_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.prev = d_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '{prev: RST_VAL};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rise_o = d_i & ~st_ff.prev;
    assign fall_o = ~d_i & st_ff.prev;

endmodule

/* src/cmpc_resync.sv */
// output stage: follows its input freely or only on a timer tick
`timescale 1ns/1ps

module cmpc_resync (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // data and control
    input wire logic d_i,
    input wire logic sync_en_i,
    input wire logic tick_i,
    // registered output
    output logic q_o
);

    typedef struct packed {
        logic q;
    } cmpc_resync_st_t;

    cmpc_resync_st_t st_ff;
    cmpc_resync_st_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (!sync_en_i) begin
            nxt_st.q = d_i;
        end else if (tick_i) begin
            nxt_st.q = d_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '{q: cmpc_pkg::RST_LEVEL};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q_o = st_ff.q;

endmodule

/* src/cmpc_top.sv */
// comparator output control: polarity, resync, edge interrupt, wishbone registers
//
// The register offsets and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps

module cmpc_top #(
    parameter int unsigned DATA_W = 32,
    parameter int unsigned ADDR_W = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [DATA_W/8-1:0] wb_sel_i,
    input wire logic [DATA_W-1:0] wb_dat_i,
    output logic [DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    // analog front end
    input wire logic cmp_raw_i,
    output logic speed_power_select_o,
    output logic hysteresis_enable_o,
    output logic [cmpc_pkg::POS_SEL_W-1:0] positive_input_select_o,
    output logic [cmpc_pkg::NEG_SEL_W-1:0] negative_input_select_o,
    // timer clock source and output path
    input wire logic resync_timer_clk_i,
    output logic cmp_out_o,
    // interrupt
    output logic irq_o
);

    // ==================================================
    // elaboration checks
    generate
        if (DATA_W != 32) begin : g_bad_data
            $error("cmpc_top: DATA_W must be 32");
        end
        if (ADDR_W < 8) begin : g_bad_addr
            $error("cmpc_top: ADDR_W must be at least 8");
        end
    endgenerate

    // ==================================================
    // state
    typedef struct packed {
        logic ack;
        cmpc_pkg::cmpc_bus_t bus;
        logic [DATA_W-1:0] rdata;
        logic [7:0] ctrl0;
        logic [7:0] ctrl1;
        logic [1:0] stat;
        logic [1:0] mask;
        logic result;
        logic out_prev;
        logic irq;
        logic speed;
        logic hyst;
        logic [cmpc_pkg::POS_SEL_W-1:0] pos_sel;
        logic [cmpc_pkg::NEG_SEL_W-1:0] neg_sel;
    } cmpc_top_st_t;

    cmpc_top_st_t st_ff;
    cmpc_top_st_t nxt_st;

    // ==================================================
    // helpers
    function automatic logic reg_hit(input logic [ADDR_W-1:0] adr, input logic [7:0] ofs);
        reg_hit = (adr[7:0] == ofs) && ((ADDR_W == 8) || (adr >> 8) == '0);
    endfunction

    // only writable bits change; the rest keep their stored value
    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wr, input logic [7:0] msk);
        merge = (old & ~msk) | (wr & msk);
    endfunction

    function automatic logic [DATA_W-1:0] widen(input logic [7:0] b);
        widen = {{(DATA_W-8){1'b0}}, b};
    endfunction

    // ==================================================
    // edge detection of the result bit and the timer clock
    logic res_rise;
    logic res_fall;
    logic tmr_rise_unused;
    logic tmr_fall;
    logic out_q;

    cmpc_edge #(
        .RST_VAL(cmpc_pkg::RST_LEVEL)
    ) u_res_edge (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(st_ff.result),
        .rise_o(res_rise),
        .fall_o(res_fall)
    );

    // timer clock is treated as a synchronous level; its fall is the update tick
    cmpc_edge #(
        .RST_VAL(cmpc_pkg::RST_LEVEL)
    ) u_tmr_edge (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(resync_timer_clk_i),
        .rise_o(tmr_rise_unused),
        .fall_o(tmr_fall)
    );

    // ==================================================
    // output path to timer and pin
    cmpc_resync u_resync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(st_ff.result),
        .sync_en_i(st_ff.ctrl0[cmpc_pkg::C0_RESYNC]),
        .tick_i(tmr_fall),
        .q_o(out_q)
    );

    // ==================================================
    // next state
    logic req;
    logic wr_en;
    logic rd_en;
    logic [1:0] ev_set;
    logic [7:0] rbyte;

    always_comb begin
        nxt_st = st_ff;
        req = 1'b0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        ev_set = 2'b00;
        rbyte = 8'h00;

        // raw input is high when the positive input exceeds the negative one
        nxt_st.result = cmp_raw_i ^ st_ff.ctrl0[cmpc_pkg::C0_INVERT];

        // result edges, each gated by its own direction enable; any output change is flagged
        ev_set[cmpc_pkg::EV_CMP] = (res_rise & st_ff.ctrl1[cmpc_pkg::C1_RISE])
            | (res_fall & st_ff.ctrl1[cmpc_pkg::C1_FALL]);
        nxt_st.out_prev = out_q;
        ev_set[cmpc_pkg::EV_OUT] = out_q ^ st_ff.out_prev;

        // bus handshake: one request taken per idle cycle, ack one cycle later
        case (st_ff.bus)
            cmpc_pkg::BUS_IDLE: begin
                req = wb_cyc_i & wb_stb_i;
                nxt_st.ack = req;
                if (req) begin
                    nxt_st.bus = cmpc_pkg::BUS_ACK;
                end
            end
            cmpc_pkg::BUS_ACK: begin
                nxt_st.ack = 1'b0;
                nxt_st.bus = cmpc_pkg::BUS_IDLE;
            end
            default: begin
                nxt_st.ack = 1'b0;
                nxt_st.bus = cmpc_pkg::BUS_IDLE;
            end
        endcase
        wr_en = req & wb_we_i & wb_sel_i[0];
        rd_en = req & ~wb_we_i;

        // register writes
        if (wr_en && reg_hit(wb_adr_i, cmpc_pkg::OFS_CTRL0)) begin
            nxt_st.ctrl0 = merge(st_ff.ctrl0, wb_dat_i[7:0], cmpc_pkg::C0_WR_MASK);
        end
        if (wr_en && reg_hit(wb_adr_i, cmpc_pkg::OFS_CTRL1)) begin
            nxt_st.ctrl1 = merge(st_ff.ctrl1, wb_dat_i[7:0], cmpc_pkg::C1_WR_MASK);
        end
        if (wr_en && reg_hit(wb_adr_i, cmpc_pkg::OFS_MASK)) begin
            nxt_st.mask = wb_dat_i[cmpc_pkg::EVT_W-1:0];
        end

        // read data; the result bit is live, not stored by software
        if (reg_hit(wb_adr_i, cmpc_pkg::OFS_CTRL0)) begin
            rbyte = st_ff.ctrl0 & cmpc_pkg::C0_WR_MASK;
            rbyte[cmpc_pkg::C0_RESULT] = st_ff.result;
        end else if (reg_hit(wb_adr_i, cmpc_pkg::OFS_CTRL1)) begin
            rbyte = st_ff.ctrl1 & cmpc_pkg::C1_WR_MASK;
        end else if (reg_hit(wb_adr_i, cmpc_pkg::OFS_STAT)) begin
            rbyte = {6'h00, st_ff.stat};
        end else if (reg_hit(wb_adr_i, cmpc_pkg::OFS_MASK)) begin
            rbyte = {6'h00, st_ff.mask};
        end
        if (rd_en) begin
            nxt_st.rdata = widen(rbyte);
        end else if (st_ff.bus == cmpc_pkg::BUS_ACK) begin
            nxt_st.rdata = '0;
        end

        // sticky status: read clears, a same-cycle event still wins
        if (rd_en && reg_hit(wb_adr_i, cmpc_pkg::OFS_STAT)) begin
            nxt_st.stat = ev_set;
        end else begin
            nxt_st.stat = st_ff.stat | ev_set;
        end
        nxt_st.irq = |(nxt_st.stat & nxt_st.mask);

        // analog configuration, registered so the pins come from flops
        nxt_st.speed = nxt_st.ctrl0[cmpc_pkg::C0_SPEED];
        nxt_st.hyst = nxt_st.ctrl0[cmpc_pkg::C0_HYST];
        nxt_st.pos_sel = nxt_st.ctrl1[cmpc_pkg::C1_POS_LSB +: cmpc_pkg::POS_SEL_W];
        nxt_st.neg_sel = nxt_st.ctrl1[cmpc_pkg::C1_NEG_LSB +: cmpc_pkg::NEG_SEL_W];
    end

    // ==================================================
    // registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff.ack <= 1'b0;
            st_ff.bus <= cmpc_pkg::BUS_IDLE;
            st_ff.rdata <= '0;
            st_ff.ctrl0 <= cmpc_pkg::RST_CTRL0;
            st_ff.ctrl1 <= cmpc_pkg::RST_CTRL1;
            st_ff.stat <= cmpc_pkg::RST_EVT;
            st_ff.mask <= cmpc_pkg::RST_EVT;
            st_ff.result <= cmpc_pkg::RST_LEVEL;
            st_ff.out_prev <= cmpc_pkg::RST_LEVEL;
            st_ff.irq <= 1'b0;
            st_ff.speed <= cmpc_pkg::RST_CTRL0[cmpc_pkg::C0_SPEED];
            st_ff.hyst <= cmpc_pkg::RST_CTRL0[cmpc_pkg::C0_HYST];
            st_ff.pos_sel <= cmpc_pkg::RST_CTRL1[cmpc_pkg::C1_POS_LSB +: cmpc_pkg::POS_SEL_W];
            st_ff.neg_sel <= cmpc_pkg::RST_CTRL1[cmpc_pkg::C1_NEG_LSB +: cmpc_pkg::NEG_SEL_W];
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==================================================
    // outputs
    assign wb_dat_o = st_ff.rdata;
    assign wb_ack_o = st_ff.ack;
    assign speed_power_select_o = st_ff.speed;
    assign hysteresis_enable_o = st_ff.hyst;
    assign positive_input_select_o = st_ff.pos_sel;
    assign negative_input_select_o = st_ff.neg_sel;
    assign cmp_out_o = out_q;
    assign irq_o = st_ff.irq;

endmodule

/* verif/cmpc_checker.sv */
// port assertions for the comparator output control block
`timescale 1ns/1ps
module cmpc_checker (
    // watched ports
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic cmp_raw_i,
    input wire logic speed_power_select_o,
    input wire logic hysteresis_enable_o,
    input wire logic resync_timer_clk_i,
    input wire logic cmp_out_o
);
    // ==================================================
    // shadow of control zero, one cycle behind the design
    logic wr0;
    logic inv_ff;
    logic sync_ff;
    logic tmr_ff;
    logic [2:0] fell_ff;
    logic [2:0] age_ff;
    assign wr0 = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == cmpc_pkg::OFS_CTRL0;
    always_ff @(posedge clk_i) begin
        tmr_ff <= resync_timer_clk_i;
        fell_ff <= {fell_ff[1:0], tmr_ff & ~resync_timer_clk_i};
        if (rst_i || wr0) begin
            age_ff <= 3'h0;
        end else if (age_ff != 3'h7) begin
            age_ff <= age_ff + 3'h1;
        end
        if (rst_i) begin
            inv_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else if (wr0) begin
            inv_ff <= wb_dat_i[4];
            sync_ff <= wb_dat_i[0];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ==================================================
    // assertions
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held over one cycle");
    property p_ack_answer;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("request not answered next cycle");
    property p_dat_idle;
        !wb_ack_o |-> wb_dat_o == 32'h0;
    endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
    property p_speed;
        wr0 |-> speed_power_select_o == wb_dat_i[2];
    endproperty
    a_speed: assert property (p_speed) else $error("speed select not written");
    property p_hyst;
        $changed(hysteresis_enable_o) |-> wr0 && hysteresis_enable_o == wb_dat_i[1];
    endproperty
    a_hyst: assert property (p_hyst) else $error("hysteresis moved without write");
    property p_free;
        !sync_ff && age_ff == 3'h7 |-> cmp_out_o == ($past(cmp_raw_i, 2) ^ inv_ff);
    endproperty
    a_free: assert property (p_free) else $error("free output wrong");
    property p_hold;
        sync_ff && age_ff == 3'h7 && $changed(cmp_out_o) |-> fell_ff != 3'h0;
    endproperty
    a_hold: assert property (p_hold) else $error("resync output moved off tick");
    property p_result;
        wb_ack_o && !wb_we_i && wb_adr_i == cmpc_pkg::OFS_CTRL0 && age_ff >= 3'h2
            |-> wb_dat_o[6] == ($past(cmp_raw_i, 2) ^ inv_ff);
    endproperty
    a_result: assert property (p_result) else $error("result bit wrong");
endmodule

/* verif/test_cmpc_top.sv */
// self-checking bench for the comparator output control block
`timescale 1ns/1ps
module test_cmpc_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic cmp_raw_i = 1'b0;
    logic resync_timer_clk_i = 1'b1;
    logic speed_o;
    logic hyst_o;
    logic [1:0] pos_sel;
    logic [2:0] neg_sel;
    logic cmp_out_o;
    logic irq_o;
    logic [31:0] seed = 32'h2f;
    logic [31:0] v;
    logic [31:0] r;
    logic [7:0] m0;
    logic [7:0] m1;
    logic ex;
    int fail_count = 0;
    int checks = 0;
    int cyc_n = 0;
    logic [7:0] ofs [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
    logic [7:0] rstv [5] = '{cmpc_pkg::RST_CTRL0, cmpc_pkg::RST_CTRL1, 8'h00, 8'h00, 8'h00};
    always #5 clk_i = ~clk_i;
    cmpc_top u_cmpc_top (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .cmp_raw_i(cmp_raw_i), .speed_power_select_o(speed_o),
        .hysteresis_enable_o(hyst_o), .positive_input_select_o(pos_sel),
        .negative_input_select_o(neg_sel), .resync_timer_clk_i(resync_timer_clk_i),
        .cmp_out_o(cmp_out_o), .irq_o(irq_o));
    // ==================================================
    // helpers
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_of_test();
        if (fail_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // one classic cycle; the master never assumes the slave latency
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                       output logic [31:0] q);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= {24'h0, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 5000) begin
            fail_count++;
            end_of_test();
        end
    end
    // ==================================================
    // scenarios
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, ofs[i], 8'h00, 4'hf, r);
            chk("reset value", r, {24'h0, rstv[i]});
        end
        chk("speed after reset", speed_o, 1'b1);
        // resync stays off here so the output follows the result freely
        for (int i = 0; i < 8; i++) begin
            v = xs();
            m0 = v[7:0] & 8'hfe & cmpc_pkg::C0_WR_MASK;
            m1 = v[15:8] & cmpc_pkg::C1_WR_MASK;
            cmp_raw_i <= v[16];
            bus(1'b1, 8'h00, v[7:0] & 8'hfe, {v[19:17], 1'b1}, r);
            bus(1'b1, 8'h04, v[15:8], {v[22:20], 1'b1}, r);
            chk("speed", speed_o, m0[2]);
            chk("hysteresis", hyst_o, m0[1]);
            chk("selects", {pos_sel, neg_sel}, {m1[5:4], m1[2:0]});
            bus(1'b0, 8'h00, 8'h00, 4'hf, r);
            chk("ctrl0", r, {24'h0, m0 | {1'b0, v[16] ^ m0[4], 6'h0}});
            bus(1'b0, 8'h04, 8'h00, 4'hf, r);
            chk("ctrl1", r, {24'h0, m1});
        end
        bus(1'b1, 8'h04, 8'h00, 4'he, r);
        bus(1'b1, 8'h10, 8'hff, 4'hf, r);
        bus(1'b0, 8'h04, 8'h00, 4'hf, r);
        chk("ctrl1 kept", r, {24'h0, m1});
        bus(1'b0, 8'h10, 8'h00, 4'hf, r);
        chk("unmapped", r, 32'h0);
        cmp_raw_i <= 1'b0;
        // every edge-enable pair under both polarities; mask off when inverted
        for (int k = 0; k < 8; k++) begin
            bus(1'b1, 8'h00, {3'h0, k[2], 4'h4}, 4'h1, r);
            bus(1'b1, 8'h04, {k[1:0], 6'h0}, 4'h1, r);
            bus(1'b1, 8'h0c, {7'h0, ~k[2]}, 4'h1, r);
            repeat (4) @(posedge clk_i);
            bus(1'b0, 8'h08, 8'h00, 4'hf, r);
            for (int e = 0; e < 2; e++) begin
                cmp_raw_i <= ~cmp_raw_i;
                repeat (4) @(posedge clk_i);
                ex = (cmp_raw_i ^ k[2]) ? k[1] : k[0];
                chk("irq", irq_o, ex & ~k[2]);
                bus(1'b0, 8'h08, 8'h00, 4'hf, r);
                chk("flag", r[0], ex);
            end
        end
        bus(1'b1, 8'h00, 8'h05, 4'h1, r);
        resync_timer_clk_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        resync_timer_clk_i <= 1'b1;
        cmp_raw_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        chk("held", cmp_out_o, 1'b0);
        bus(1'b0, 8'h08, 8'h00, 4'hf, r);
        resync_timer_clk_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk("loaded", cmp_out_o, 1'b1);
        bus(1'b0, 8'h08, 8'h00, 4'hf, r);
        chk("output change event", r[1], 1'b1);
        bus(1'b1, 8'h00, 8'h04, 4'h1, r);
        cmp_raw_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk("free", cmp_out_o, 1'b0);
        end_of_test();
    end
endmodule
bind cmpc_top cmpc_checker u_cmpc_checker (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .cmp_raw_i(cmp_raw_i), .speed_power_select_o(speed_power_select_o),
    .hysteresis_enable_o(hysteresis_enable_o), .resync_timer_clk_i(resync_timer_clk_i),
    .cmp_out_o(cmp_out_o));
